// [bench/sipc_host.sv]
// Behavioural I2C controller that drives SCL and pulls SDA low, for the target bench.
// Assumes the bench resolves the SDA wire with a pull-up and feeds it back on sda_in.
`timescale 1ns/1ns
module sipc_host (
  // Clock and bus wire
  input  wire logic clk_in,
  input  wire logic sda_in,
  // Driven pins
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle bus: SCL high and SDA released, so the link clock stands still between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold

  // One SCL period of 40 cycles, 160 ns; data changes only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= !b;
    hold(10);
    scl_out <= 1'b1;
    hold(10);
    r = sda_in;
    hold(10);
    scl_out <= 1'b0;
    hold(10);
  endtask : bit_io

  // Release SDA before raising SCL, so a repeated start never looks like a stop
  task automatic start();
    sda_low_out <= 1'b0;
    hold(10);
    scl_out <= 1'b1;
    hold(10);
    sda_low_out <= 1'b1;
    hold(10);
    scl_out <= 1'b0;
    hold(10);
  endtask : start

  // Host may stop after a refused byte
  task automatic stop();
    sda_low_out <= 1'b1;
    hold(10);
    scl_out <= 1'b1;
    hold(10);
    sda_low_out <= 1'b0;
    hold(10);
  endtask : stop

  // Byte out, MSB first, then the ninth clock samples the target's answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte

  // Host acknowledges every byte but the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rbyte
endmodule : sipc_host

// [bench/sipc_top_tb_top.sv]
// Self-checking bench for the sensor I2C target and its power-state sequencing.
// Assumes sipc_host as bus controller and a behavioural register file fed from here.
`timescale 1ns/1ns
module sipc_top_tb_top;
  import sipc_pkg::*;
  // Short blackout keeps the run brief; long enough to refuse a whole address byte
  localparam int INIT_N = 1000;
  logic        clk_in, reset_n_in, scl, host_low, sda_out, sda_oe_out, irq_in, ack;
  logic [7:0]  reg_rdata_in, ptr, d, rb [2];
  logic [15:0] field16_in, cap;
  logic [31:0] seed;
  sipc_req_t   reg_req_out, got, exp_q [$];
  sipc_pwr_t   pwr_out;
  int          err_count, n_checks;
  wire         sda_w = !host_low && (sda_oe_out ? sda_out : 1'b1);

  sipc_top #(.INIT_CNT(INIT_N)) u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .reg_req_out(reg_req_out), .reg_rdata_in(reg_rdata_in), .field16_in(field16_in),
    .irq_in(irq_in), .pwr_out(pwr_out));
  sipc_host u_host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(host_low));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // Clock, 4 ns period
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Register file: data follows the pointer; the field moves after each read strobe,
  // so a high byte taken live instead of from the latch shows up as a mismatch
  always @(posedge clk_in) begin
    reg_rdata_in <= reg_req_out.addr ^ 8'h5A;
    if (reg_req_out.rd) begin
      field16_in <= seed[15:0];
      seed <= xs(seed);
      if (reg_req_out.addr == 8'h84) cap <= field16_in;
    end
  end

  // Strobe monitor: each write or read strobe is matched to the oldest note
  always @(posedge clk_in) begin
    if (reg_req_out.wr || reg_req_out.rd) begin
      got = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
      chk(reg_req_out.wr ? 18'(reg_req_out) : {reg_req_out[17:8], 8'h00}, got);
    end
  end

  // Start plus address byte; ack tells whether the target took it
  task automatic addr_phase(input logic rd_bit, input logic exp_ack);
    u_host.start();
    u_host.wbyte({TGT_ADDR, rd_bit}, ack);
    chk(ack, exp_ack);
  endtask : addr_phase

  // Register byte, then n data bytes written at the advancing pointer
  task automatic wr(input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    addr_phase(1'b0, 1'b1);
    u_host.wbyte(ra, ack);
    chk(ack, 1'b1);
    ptr = ra;
    for (int i = 0; i < n; i++) begin
      d = (i != 0) ? d1 : d0;
      exp_q.push_back({2'b10, ptr, d});
      u_host.wbyte(d, ack);
      chk(ack, 1'b1);
      ptr++;
    end
    u_host.stop();
  endtask : wr

  // Read of n bytes, with or without the register byte and repeated start
  task automatic rd(input logic [7:0] ra, input logic use_ra, input int n);
    if (use_ra) begin
      addr_phase(1'b0, 1'b1);
      u_host.wbyte(ra, ack);
      chk(ack, 1'b1);
      ptr = ra;
    end
    // Each read strobe leaves on the ninth clock before its byte, so note them all first
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({2'b01, ptr, 8'h00});
      ptr++;
    end
    addr_phase(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_host.rbyte(i == n - 1, rb[i]);
    end
    u_host.stop();
  endtask : rd

  // Watchdog: the sequence needs about 70 us
  initial begin
    #200000;
    err_count++;
    conclude();
  end

  initial begin
    reset_n_in = 1'b0;
    irq_in = 1'b0;
    field16_in = 16'h1234;
    reg_rdata_in = 8'h00;
    seed = 32'h38B4;
    repeat (5) @(posedge clk_in);
    chk(pwr_out, 5'b10000);
    reset_n_in <= 1'b1;
    addr_phase(1'b0, 1'b0);
    u_host.stop();
    for (int i = 0; i < INIT_N && pwr_out.init_busy; i++) @(posedge clk_in);
    @(posedge clk_in);
    chk(pwr_out, 5'b00000);
    $display("test blackout done");
    wr(ADDR_ENABLE, 8'h01, 8'h00, 1);
    chk(pwr_out, 5'b01000);
    u_host.start();
    u_host.wbyte({TGT_ADDR ^ 7'h01, 1'b0}, ack);
    chk(ack, 1'b0);
    u_host.stop();
    wr(ADDR_CFG0, 8'h40, 8'h00, 1);
    wr(ADDR_CFG3, 8'h1C, seed[7:0], 2);
    wr(ADDR_ENABLE, 8'h03, 8'h00, 1);
    chk(pwr_out, 5'b01110);
    $display("test power and writes done");
    rd(8'h00, 1'b0, 1);
    chk(rb[0], 8'h81 ^ 8'h5A);
    rd(8'h84, 1'b1, 2);
    chk(rb[1], cap[15:8]);
    wr(8'h84, seed[7:0], seed[15:8], 2);
    $display("test pointer and latch done");
    @(posedge clk_in);
    irq_in <= 1'b1;
    @(posedge clk_in);
    irq_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(pwr_out, 5'b00001);
    rd(ADDR_ENABLE, 1'b1, 1);
    chk(rb[0], 8'h03);
    rd(ADDR_STATUS6, 1'b1, 1);
    chk(rb[0] & 8'h02, 8'h02);
    wr(ADDR_CONTROL, 8'h02, 8'h00, 1);
    chk(pwr_out, 5'b01110);
    $display("test interrupt sleep done");
    wr(ADDR_ENABLE, 8'h01, 8'h00, 1);
    chk(pwr_out, 5'b01000);
    wr(ADDR_ENABLE, 8'h00, 8'h00, 1);
    chk(pwr_out, 5'b00000);
    repeat (4) @(posedge clk_in);
    chk(exp_q.size(), 18'h0);
    $display("test power down done");
    conclude();
  end
endmodule : sipc_top_tb_top

// [verilog/sipc_pkg.sv]
// Shared constants and types for the sensor I2C target and power-state control.
// Assumes a single 250 MHz clock; the I2C pins are asynchronous to it.
package sipc_pkg;
  // Clock and power-on blackout timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          INIT_TIME_NS   = 200000;
  localparam int          INIT_CYCLES    = INIT_TIME_NS / CLK_PERIOD_NS;
  // Target address, arbitrary neutral value
  localparam logic [6:0]  TGT_ADDR       = 7'h2A;
  // Register addresses handled inside this block
  localparam logic [7:0]  ADDR_ENABLE    = 8'h80;
  localparam logic [7:0]  ADDR_STATUS6   = 8'hA7;
  localparam logic [7:0]  ADDR_CFG0      = 8'hA9;
  localparam logic [7:0]  ADDR_CFG3      = 8'hAC;
  localparam logic [7:0]  ADDR_CONTROL   = 8'hFA;
  // Field positions
  localparam int          BIT_PON        = 0;
  localparam int          BIT_AEN        = 1;
  localparam int          BIT_SAI        = 4;
  localparam int          BIT_HOLD       = 1;
  localparam int          BIT_HOLD_CLR   = 1;
  localparam int          BIT_PAR        = 6;
  // Reset values and writable masks
  localparam logic [7:0]  RST_ENABLE     = 8'h00;
  localparam logic [7:0]  RST_CFG3       = 8'h0C;
  localparam logic [7:0]  MASK_ENABLE    = 8'h4B;
  // Low-byte addresses of the two-byte fields
  localparam logic [7:0]  LOW_ADDRS [8]  = '{8'h84, 8'h86, 8'h95, 8'h97,
                                             8'h99, 8'h9B, 8'h9D, 8'h9F};

  // Power states
  typedef enum logic [2:0] {
    PW_INIT   = 3'h0,
    PW_SLEEP  = 3'h1,
    PW_IDLE   = 3'h2,
    PW_ACTIVE = 3'h3,
    PW_HOLD   = 3'h4
  } sipc_pstate_t;

  // Bus-interface states
  typedef enum logic [2:0] {
    IS_IDLE = 3'h0,
    IS_ADDR = 3'h1,
    IS_AACK = 3'h2,
    IS_WR   = 3'h3,
    IS_WACK = 3'h4,
    IS_RD   = 3'h5,
    IS_RACK = 3'h6
  } sipc_istate_t;

  // Register access request toward the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sipc_req_t;

  // Power-state outputs
  typedef struct packed {
    logic init_busy;
    logic osc_run;
    logic als_run;
    logic color_par;
    logic sleep_hold;
  } sipc_pwr_t;
endpackage : sipc_pkg

// [verilog/sipc_top.sv]
// I2C target with register pointer, 16-bit read latch and power-state sequencing.
// Assumes open-drain SCL/SDA pins synchronised here, register file outside.
// Function
// (RULE1) After reset, 200us blackout: every transfer gets not-acknowledge.
// (RULE2) Host waits out the blackout and ignores all device outputs.
// (RULE3) Blackout ends in SLEEP with the oscillator stopped.
// (RULE4) Bus interface serves transfers during SLEEP without leaving SLEEP.
// (RULE5) power_on_bit set moves SLEEP to IDLE with oscillator running.
// (RULE6) light_sense_enable moves IDLE to active; clearing it returns to IDLE.
// (RULE7) parallel_sensing_select runs colour functions concurrently with own settings.
// (RULE8) sleep_after_interrupt makes an interrupt force SLEEP.
// (RULE9) Interrupt sleep keeps all register values, power_on_bit stays set.
// (RULE10) Interrupt sleep lasts until sleep_hold_flag is cleared via 0xFA.
// (RULE11) 7-bit target addressing, SCL up to 400 kHz.
// (RULE12) 8-bit register pointer increments after each byte.
// (RULE13) Pointer keeps its value across STOP and bus release.
// (RULE14) Read without address byte continues at previous address plus one.
// (RULE15) Low-byte read latches the 16-bit field; high byte served from latch.
// (RULE16) Host reads low byte then high byte with nothing between.
// (RULE17) Host writes low byte then high byte immediately after.
// (RULE18) Host should use bursts for two-byte quantities.
// (RULE19) Device drives ACK or NACK on the ninth clock of each byte. Code pulls ACK after address and write bytes only.
// (RULE20) Host may STOP after a not-acknowledge.
// (RULE21) Read is write-address, register, repeated START, read-address, data.
// (RULE22) Host acknowledges all read bytes but the last, then STOP.
// (RULE23) Latch holds until high byte read or next low-byte capture.
`timescale 1ns/1ns
module sipc_top #(
  parameter int INIT_CNT = sipc_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  // I2C pins, open drain
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_out,
  // Register file side
  output sipc_pkg::sipc_req_t     reg_req_out,
  input  wire logic [7:0]         reg_rdata_in,
  input  wire logic [15:0]        field16_in,
  // Measurement side
  input  wire logic               irq_in,
  output sipc_pkg::sipc_pwr_t     pwr_out
);
  import sipc_pkg::*;

  // Low-byte decode of two-byte fields, used for capture and for checks
  function automatic logic is_low(input logic [7:0] a);
    is_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      is_low = is_low | (a == LOW_ADDRS[i]);
    end
  endfunction : is_low

  // Pin synchronisers; only the second stage and its delayed copy are used
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {scl_m, scl_s, scl_q} <= 3'h7;
      {sda_m, sda_s, sda_q} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_q} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  // Power and register state
  sipc_pstate_t pstate, next_pstate;
  logic [15:0]  init_cnt, next_init_cnt;
  logic [7:0]   enable_r, next_enable_r, cfg3_r, next_cfg3_r;
  logic         par_sel, next_par_sel, hold, next_hold;
  sipc_pwr_t    next_pwr;
  // Bus-interface state
  sipc_istate_t istate, next_istate;
  logic [3:0]   bitcnt, next_bitcnt;
  logic [7:0]   shreg, next_shreg, ptr, next_ptr;
  logic         rw, next_rw, first, next_first, host_ack, next_host_ack, oe, next_oe;
  logic [15:0]  latch, next_latch;
  logic [7:0]   latch_addr, next_latch_addr, rd_byte;
  logic         latch_vld, next_latch_vld, load;
  sipc_req_t    next_req;
  // Byte served for the pointer; internal registers first, latch before the file
  always_comb begin
    case (ptr)
      ADDR_ENABLE:  rd_byte = enable_r;
      ADDR_CFG0:    rd_byte = 8'(par_sel) << BIT_PAR;
      ADDR_CFG3:    rd_byte = cfg3_r;
      ADDR_STATUS6: rd_byte = 8'(hold) << BIT_HOLD;
      default:      rd_byte = (latch_vld && ptr == latch_addr) ? latch[15:8]   // see (RULE15)
                                                               : reg_rdata_in;
    endcase
  end

  // Bus interface: runs in every power state, so SLEEP never blocks it (see (RULE4))
  always_comb begin
    next_istate     = istate;
    next_bitcnt     = bitcnt;
    next_shreg      = shreg;
    next_ptr        = ptr;
    next_rw         = rw;
    next_first      = first;
    next_host_ack   = host_ack;
    next_oe         = oe;
    next_latch      = latch;
    next_latch_addr = latch_addr;
    next_latch_vld  = latch_vld;
    next_req        = '{wr: 1'b0, rd: 1'b0, addr: ptr, wdata: reg_req_out.wdata};
    load = scl_fall && ((istate == IS_AACK && rw) || (istate == IS_RACK && host_ack));
    if (bus_start) begin
      next_istate = IS_ADDR;
      next_bitcnt = 4'h0;
      next_oe     = 1'b0;
    end else if (bus_stop) begin
      next_istate = IS_IDLE;                       // pointer kept, see (RULE13)
      next_oe     = 1'b0;
    end else if (load) begin
      next_istate = IS_RD;
      next_bitcnt = 4'h0;
      next_shreg  = rd_byte;
      next_oe     = ~rd_byte[7];
      next_req.rd = 1'b1;
      if (is_low(ptr)) begin                       // see (RULE15)
        next_latch      = field16_in;
        next_latch_addr = ptr + 8'h01;
        next_latch_vld  = 1'b1;
      end else if (latch_vld && ptr == latch_addr) begin
        next_latch_vld  = 1'b0;                    // see (RULE23)
      end
    end else begin
      case (istate)
        IS_ADDR, IS_WR: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            if (istate == IS_WR) begin
              next_oe     = 1'b1;                  // see (RULE19)
              next_istate = IS_WACK;
              next_first  = 1'b0;
              if (first) begin
                next_ptr = shreg;                  // see (RULE12)
              end else begin
                next_req = '{wr: 1'b1, rd: 1'b0, addr: ptr, wdata: shreg};
                next_ptr = ptr + 8'h01;            // see (RULE12)
              end
            end else if (shreg[7:1] == TGT_ADDR && pstate != PW_INIT) begin
              next_oe     = 1'b1;                  // see (RULE11) (RULE19)
              next_rw     = shreg[0];
              next_istate = IS_AACK;
            end else begin
              next_istate = IS_IDLE;               // silence is NACK, see (RULE1)
            end
          end
        end
        IS_AACK, IS_WACK: begin
          if (scl_fall) begin
            next_oe     = 1'b0;
            next_istate = IS_WR;
            next_bitcnt = 4'h0;
            next_first  = (istate == IS_AACK) ? 1'b1 : first;
          end
        end
        IS_RD: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              next_oe     = 1'b0;
              next_istate = IS_RACK;
              next_ptr    = ptr + 8'h01;           // see (RULE12) (RULE14)
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe    = ~shreg[6];
            end
          end
        end
        IS_RACK: begin
          if (scl_rise) begin
            next_host_ack = ~sda_s;
          end else if (scl_fall) begin
            next_istate = IS_IDLE;                 // host NACK ends the read
          end
        end
        default: next_istate = IS_IDLE;
      endcase
    end
  end
  // Power sequencing and the registers it owns
  always_comb begin
    logic clr;
    clr           = reg_req_out.wr && reg_req_out.addr == ADDR_CONTROL
                    && reg_req_out.wdata[BIT_HOLD_CLR];
    next_pstate   = pstate;
    next_init_cnt = init_cnt;
    next_enable_r = enable_r;
    next_cfg3_r   = cfg3_r;
    next_par_sel  = par_sel;
    if (reg_req_out.wr) begin
      case (reg_req_out.addr)
        ADDR_ENABLE: next_enable_r = reg_req_out.wdata[BIT_PON] ? reg_req_out.wdata & MASK_ENABLE
                                                                : RST_ENABLE;
        ADDR_CFG3:   next_cfg3_r   = reg_req_out.wdata;
        ADDR_CFG0:   next_par_sel  = reg_req_out.wdata[BIT_PAR];
        default:     next_cfg3_r   = cfg3_r;
      endcase
    end
    // Set beats clear, but hold is only cleared in HOLD, where irq_in is ignored, so an interrupt in the clearing cycle is lost
    next_hold = (hold & ~clr) | (irq_in && cfg3_r[BIT_SAI]
                 && (pstate == PW_IDLE || pstate == PW_ACTIVE));   // see (RULE8) (RULE10)
    case (pstate)
      PW_INIT: begin
        next_init_cnt = init_cnt + 16'h0001;
        if (init_cnt == 16'(INIT_CNT - 1)) begin
          next_pstate = PW_SLEEP;                  // see (RULE3)
        end
      end
      PW_SLEEP:  if (enable_r[BIT_PON]) next_pstate = PW_IDLE;    // see (RULE5)
      PW_IDLE, PW_ACTIVE: begin
        if (next_hold) begin
          next_pstate = PW_HOLD;                   // see (RULE8) (RULE9)
        end else if (!enable_r[BIT_PON]) begin
          next_pstate = PW_SLEEP;
        end else begin
          next_pstate = enable_r[BIT_AEN] ? PW_ACTIVE : PW_IDLE;  // see (RULE6)
        end
      end
      PW_HOLD:   if (!hold) next_pstate = enable_r[BIT_PON] ? PW_IDLE : PW_SLEEP; // see (RULE10)
      default:   next_pstate = PW_INIT;
    endcase
    next_pwr.init_busy  = next_pstate == PW_INIT;
    next_pwr.osc_run    = next_pstate == PW_IDLE || next_pstate == PW_ACTIVE;
    next_pwr.als_run    = next_pstate == PW_ACTIVE;
    next_pwr.color_par  = next_pstate == PW_ACTIVE && next_par_sel;          // see (RULE7)
    next_pwr.sleep_hold = next_hold;
  end

  // All state registers; SDA is only ever pulled low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pstate <= PW_INIT;  init_cnt <= 16'h0000;  enable_r <= RST_ENABLE;
      cfg3_r <= RST_CFG3; par_sel <= 1'b0;       hold <= 1'b0;
      pwr_out <= '{init_busy: 1'b1, default: 1'b0};
      istate <= IS_IDLE;  bitcnt <= 4'h0;  shreg <= 8'h00;  ptr <= 8'h00;
      rw <= 1'b0;  first <= 1'b0;  host_ack <= 1'b0;  oe <= 1'b0;
      latch <= 16'h0000;  latch_addr <= 8'h00;  latch_vld <= 1'b0;
      reg_req_out <= '0;  sda_out <= 1'b0;  sda_oe_out <= 1'b0;
    end else begin
      pstate <= next_pstate;  init_cnt <= next_init_cnt;  enable_r <= next_enable_r;
      cfg3_r <= next_cfg3_r;  par_sel <= next_par_sel;    hold <= next_hold;
      pwr_out <= next_pwr;
      istate <= next_istate;  bitcnt <= next_bitcnt;  shreg <= next_shreg;
      ptr <= next_ptr;  rw <= next_rw;  first <= next_first;  host_ack <= next_host_ack;
      oe <= next_oe;  latch <= next_latch;  latch_addr <= next_latch_addr;
      latch_vld <= next_latch_vld;  reg_req_out <= next_req;
      sda_out <= 1'b0;  sda_oe_out <= next_oe;
    end
  end
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_INIT_NAK: assert property (pstate == PW_INIT |-> !sda_oe_out)   // see (RULE1)
    else $error("SDA driven during power-on blackout");
  AST_INIT_SLEEP: assert property (pstate == PW_INIT && next_pstate != PW_INIT // see (RULE3)
    |=> pstate == PW_SLEEP ##1 pwr_out.osc_run == 1'b0)
    else $error("Blackout did not end in SLEEP");
  AST_PON_IDLE: assert property (pstate == PW_SLEEP && enable_r[BIT_PON] // see (RULE5)
    |=> pstate == PW_IDLE && pwr_out.osc_run)
    else $error("Power-on did not reach IDLE");
  AST_AEN_ACTIVE: assert property (pstate == PW_IDLE && enable_r[BIT_PON] // see (RULE6)
    && enable_r[BIT_AEN] && !next_hold |=> pstate == PW_ACTIVE)
    else $error("Enable did not start measurement");
  AST_SAI_SLEEP: assert property (pstate == PW_ACTIVE && irq_in && cfg3_r[BIT_SAI] // see (RULE8)
    && !reg_req_out.wr |=> pstate == PW_HOLD && hold && $stable(enable_r)) // see (RULE9)
    else $error("Interrupt did not force SLEEP");
  AST_HOLD_STAY: assert property (pstate == PW_HOLD && hold |=> pstate == PW_HOLD) // see (RULE10)
    else $error("Left SLEEP while hold flag set");
  AST_PTR_INC: assert property (istate == IS_RD && scl_fall && bitcnt == 4'h7 // see (RULE12)
    |=> ptr == $past(ptr) + 8'h01)
    else $error("Pointer did not advance after read byte");
  AST_PTR_KEEP: assert property (bus_stop |=> $stable(ptr))           // see (RULE13)
    else $error("Pointer changed on STOP");
  AST_ACK_NINTH: assert property (istate == IS_WR && scl_fall && bitcnt == 4'h8 // see (RULE19)
    |=> istate == IS_WACK ##1 sda_oe_out)
    else $error("No acknowledge on ninth clock");
  AST_LATCH_HI: assert property (load && latch_vld && ptr == latch_addr // see (RULE15)
    |=> shreg == $past(latch[15:8]))
    else $error("High byte not served from latch");
  AST_CAP: assert property (load && is_low(ptr) |=> latch == $past(field16_in)) // see (RULE15)
    else $error("Low-byte read did not capture the field");
  COV_READ: cover property (istate == IS_RACK && scl_fall && host_ack);
  COV_WRITE: cover property (reg_req_out.wr);
  COV_HOLD: cover property (pstate == PW_HOLD ##1 pstate == PW_IDLE);
endmodule : sipc_top
